// file: obl_core.sv
`timescale 1ns/1ns
`default_nettype none
module obl_core #(
   parameter int NUM_BLOCKS = obl_pkg::NUM_BLOCKS_DEF,
   parameter logic [7:0] OP_ENTER_SECURE = obl_pkg::OP_ENTER_SECURE_DEF,
   parameter logic [7:0] OP_EXIT_SECURE = obl_pkg::OP_EXIT_SECURE_DEF,
   parameter logic [7:0] OP_READ_SEC = obl_pkg::OP_READ_SEC_DEF,
   parameter logic [7:0] OP_WRITE_SEC = obl_pkg::OP_WRITE_SEC_DEF,
   parameter logic [7:0] OP_PROTECT_SEL = obl_pkg::OP_PROTECT_SEL_DEF
) (
   input wire logic clk_i,               // 100 MHz system clock
   input wire logic sys_rst_i,           // synchronous reset, high
   input wire logic ce_i,                // clock enable, freezes all state
   input wire logic cs_n_i,              // chip select pin, low active
   input wire logic sclk_i,              // serial clock pin
   input wire logic si_i,                // serial data in pin
   input wire logic wp_n_i,              // write protect pin, low active
   output logic so_o,                    // serial data out
   output logic so_oe_n_o,               // serial out enable, low drives
   input wire logic nv_factory_lock_i,   // stored factory lock bit
   input wire logic nv_lockdown_i,       // stored customer lockdown bit
   input wire logic nv_protect_sel_i,    // stored protection select bit
   output logic nv_lockdown_set_o,       // pulse: store lockdown bit
   output logic nv_protect_sel_set_o,    // pulse: store protection select
   input wire logic continuous_program_mode_i,           // continuous program mode level
   input wire logic program_fail_i,      // pulse: program failed
   input wire logic erase_fail_i,        // pulse: erase failed
   input wire logic array_req_i,         // pulse: program or erase request
   input wire logic array_erase_i,       // request is an erase
   input wire logic [23:0] array_addr_i, // request address
   input wire logic range_protect_hit_i, // range protect bits cover address
   output logic array_allow_o,           // request may proceed
   output logic otp_mode_o,              // array accesses hit secured area
   output logic [7:0] opcode_o,          // last received opcode
   output logic opcode_valid_o,          // pulse: opcode_o is new
   output logic opcode_allowed_o,        // opcode may be carried out
   output logic [7:0] security_reg_o     // security register value
);
   typedef enum {
      ST_IDLE,
      ST_CMD,
      ST_READ
   } obl_frame_type;

   typedef struct packed {
      obl_frame_type frame;
      logic sclk_q;
      logic cs_q;
      logic nv_loaded;
      logic [7:0] shift_in;
      logic [2:0] bit_cnt;
      logic [2:0] byte_cnt;
      logic [7:0] opcode;
      logic [23:0] addr;
      logic [7:0] out_sh;
      logic [2:0] out_cnt;
      logic so;
      logic so_oe_n;
      logic op_valid;
      logic op_allowed;
      logic otp_mode;
      logic wel;
      logic factory_lock;
      logic lockdown;
      logic protect_sel;
      logic prog_fail;
      logic erase_fail;
      logic nv_lockdown_set;
      logic nv_protect_set;
      logic lk_one;
      logic lk_all;
      logic lk_val;
   } obl_core_state_type;

   obl_core_state_type s;
   obl_core_state_type next_s;
   logic [3:0] pins_s;
   logic cs_n_s;
   logic sclk_s;
   logic si_s;
   logic wp_n_s;
   logic blk_locked;
   logic [7:0] scur;
   logic allow;

   if (OP_ENTER_SECURE == OP_EXIT_SECURE || OP_READ_SEC == OP_WRITE_SEC) begin : g_chk
      $error("obl_core: configurable opcodes must differ");
   end

   // pins come from the host's domain, so they pass two flops first
   obl_sync #(
      .W(4),
      .RST_VAL(obl_pkg::PIN_RST_VAL)
   ) u_sync (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .ce_i(ce_i),
      .d_i({cs_n_i, sclk_i, si_i, wp_n_i}),
      .q_o(pins_s)
   );
   assign cs_n_s = pins_s[3];
   assign sclk_s = pins_s[2];
   assign si_s = pins_s[1];
   assign wp_n_s = pins_s[0];

   // lock bits all set after reset
   obl_lock_mem #(
      .NUM_BLOCKS(NUM_BLOCKS)
   ) u_locks (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .ce_i(ce_i),
      .wr_one_i(s.lk_one),
      .wr_all_i(s.lk_all),
      .wr_val_i(s.lk_val),
      .wr_addr_i(s.addr),
      .rd_addr_i(array_addr_i),
      .locked_o(blk_locked)
   );

   // register image, reserved bits read zero
   assign scur = {s.protect_sel, s.erase_fail, s.prog_fail, continuous_program_mode_i,
                  2'b00, s.lockdown, s.factory_lock};

   function automatic logic is_erase(input logic [7:0] op);
      return op == obl_pkg::OP_SECTOR_ERASE || op == obl_pkg::OP_HALF_BLOCK_ERASE ||
             op == obl_pkg::OP_BLOCK_ERASE || op == obl_pkg::OP_CHIP_ERASE_A ||
             op == obl_pkg::OP_CHIP_ERASE_B;
   endfunction

   // commands that change protection or contents, refused in secured mode
   function automatic logic secure_refused(input logic [7:0] op);
      return is_erase(op) || op == obl_pkg::OP_STATUS_WRITE || op == OP_WRITE_SEC ||
             op == OP_PROTECT_SEL || op == obl_pkg::OP_SINGLE_LOCK ||
             op == obl_pkg::OP_SINGLE_UNLOCK || op == obl_pkg::OP_WHOLE_LOCK ||
             op == obl_pkg::OP_WHOLE_UNLOCK;
   endfunction

   // protection check for program and erase requests from the array logic
   always_comb begin
      if (s.otp_mode) begin
         // no erase of the secured area
         // a locked-down area takes no program
         allow = !array_erase_i && !s.lockdown;
      end else if (s.protect_sel) begin
         allow = wp_n_s && !blk_locked;
      end else begin
         allow = !range_protect_hit_i;
      end
   end

   // serial frame decode, command execution and flag upkeep
   always_comb begin
      logic rise;
      logic fall;
      logic [7:0] byte_in;
      logic exec_ok;
      rise = 1'b0;
      fall = 1'b0;
      byte_in = 8'h00;
      exec_ok = 1'b0;
      next_s = s;
      rise = sclk_s && !s.sclk_q;
      fall = !sclk_s && s.sclk_q;
      byte_in = {s.shift_in[6:0], si_s};
      next_s.sclk_q = sclk_s;
      next_s.cs_q = cs_n_s;
      next_s.op_valid = 1'b0;
      next_s.nv_lockdown_set = 1'b0;
      next_s.nv_protect_set = 1'b0;
      next_s.lk_one = 1'b0;
      next_s.lk_all = 1'b0;
      // non-volatile bits are copied once, the cycle after reset ends
      if (!s.nv_loaded) begin
         next_s.nv_loaded = 1'b1;
         next_s.factory_lock = nv_factory_lock_i;
         next_s.lockdown = nv_lockdown_i;
         next_s.protect_sel = nv_protect_sel_i;
      end
      // clear first so that a same-cycle failure still sets
      if (cs_n_s && !s.cs_q && s.frame == ST_CMD && s.bit_cnt == 3'h0 &&
          s.byte_cnt == obl_pkg::BYTES_OPCODE_ONLY &&
          s.opcode == obl_pkg::OP_CLEAR_FAIL) begin
         next_s.prog_fail = 1'b0;
         next_s.erase_fail = 1'b0;
      end
      if (program_fail_i || (array_req_i && !array_erase_i && !allow)) begin
         next_s.prog_fail = 1'b1;
      end
      if (erase_fail_i || (array_req_i && array_erase_i && !allow)) begin
         next_s.erase_fail = 1'b1;
      end
      if (cs_n_s) begin
         next_s.frame = ST_IDLE;
         next_s.so_oe_n = 1'b1;
         // a command runs only when select rises on a byte boundary
         exec_ok = !s.cs_q && s.frame == ST_CMD && s.bit_cnt == 3'h0;
         if (exec_ok && s.byte_cnt == obl_pkg::BYTES_OPCODE_ONLY) begin
            if (s.opcode == OP_ENTER_SECURE) begin
               next_s.otp_mode = 1'b1;
            end else if (s.opcode == OP_EXIT_SECURE) begin
               next_s.otp_mode = 1'b0;
            end else if (s.opcode == obl_pkg::OP_WRITE_ENABLE) begin
               next_s.wel = 1'b1;
            end else if (s.opcode == OP_WRITE_SEC && !s.otp_mode) begin
               // no write enable needed; set-only bit
               if (!s.lockdown) begin
                  next_s.lockdown = 1'b1;
                  next_s.nv_lockdown_set = 1'b1;
               end
            end else if (s.opcode == OP_PROTECT_SEL && !s.otp_mode) begin
               if (!s.protect_sel) begin
                  next_s.protect_sel = 1'b1;
                  next_s.nv_protect_set = 1'b1;
               end
            end else if ((s.opcode == obl_pkg::OP_WHOLE_LOCK ||
                          s.opcode == obl_pkg::OP_WHOLE_UNLOCK) &&
                         s.protect_sel && s.wel && !s.otp_mode) begin
               next_s.lk_all = 1'b1;
               next_s.lk_val = s.opcode == obl_pkg::OP_WHOLE_LOCK;
               next_s.wel = 1'b0;
            end
         end else if (exec_ok && s.byte_cnt == obl_pkg::BYTES_WITH_ADDR &&
                      (s.opcode == obl_pkg::OP_SINGLE_LOCK ||
                       s.opcode == obl_pkg::OP_SINGLE_UNLOCK) &&
                      s.protect_sel && s.wel && !s.otp_mode) begin
            next_s.lk_one = 1'b1;
            next_s.lk_val = s.opcode == obl_pkg::OP_SINGLE_LOCK;
            next_s.wel = 1'b0;
         end
      end else if (s.cs_q) begin
         // select just fell: start a new frame
         next_s.frame = ST_CMD;
         next_s.bit_cnt = 3'h0;
         next_s.byte_cnt = 3'h0;
      end else if (rise && s.frame == ST_CMD) begin
         next_s.shift_in = byte_in;
         next_s.bit_cnt = s.bit_cnt + 3'h1;
         if (s.bit_cnt == obl_pkg::LAST_BIT) begin
            if (s.byte_cnt != 3'h7) begin
               next_s.byte_cnt = s.byte_cnt + 3'h1;
            end
            if (s.byte_cnt == 3'h0) begin
               next_s.opcode = byte_in;
               next_s.op_valid = 1'b1;
               next_s.op_allowed = !(s.otp_mode && secure_refused(byte_in));
               // the read is served whatever else is busy
               if (byte_in == OP_READ_SEC) begin
                  next_s.frame = ST_READ;
                  next_s.out_sh = scur;
                  next_s.out_cnt = 3'h0;
               end
            end else if (s.byte_cnt < obl_pkg::BYTES_WITH_ADDR) begin
               next_s.addr = {s.addr[15:0], byte_in};
            end
         end
      end else if (fall && s.frame == ST_READ) begin
         // bits leave MSB first on falling edges, reloaded per byte
         next_s.so = s.out_sh[7];
         next_s.so_oe_n = 1'b0;
         next_s.out_cnt = s.out_cnt + 3'h1;
         next_s.out_sh = (s.out_cnt == obl_pkg::LAST_BIT) ? scur : {s.out_sh[6:0], 1'b0};
      end
   end

   // state register, frozen while the clock enable is low
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         s <= '0;
         s.frame <= ST_IDLE;
         s.sclk_q <= 1'b0;
         s.cs_q <= 1'b1;
         s.so_oe_n <= 1'b1;
         s.lk_val <= 1'b1;
      end else if (ce_i) begin
         s <= next_s;
      end
   end

   assign so_o = s.so;
   assign so_oe_n_o = s.so_oe_n;
   assign nv_lockdown_set_o = s.nv_lockdown_set;
   assign nv_protect_sel_set_o = s.nv_protect_set;
   assign array_allow_o = allow;
   assign otp_mode_o = s.otp_mode;
   assign opcode_o = s.opcode;
   assign opcode_valid_o = s.op_valid;
   assign opcode_allowed_o = s.op_allowed;
   assign security_reg_o = scur;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);

   lockdown_sticky_a: assert property (s.nv_loaded && s.lockdown |=> s.lockdown)
      else $error("lockdown bit cleared");
   protect_sticky_a: assert property (s.nv_loaded && s.protect_sel |=> s.protect_sel)
      else $error("protection select cleared");
   otp_erase_a: assert property (array_req_i && array_erase_i && otp_mode_o
                                 |-> !array_allow_o)
      else $error("erase allowed in secured mode");
   otp_locked_prog_a: assert property (otp_mode_o && s.lockdown |-> !array_allow_o)
      else $error("locked secured area writable");
   wp_pin_protect_a: assert property (s.protect_sel && !wp_n_s && !otp_mode_o
                                      |-> !array_allow_o)
      else $error("write protect pin ignored");
   prog_fail_set_a: assert property (
      ce_i && array_req_i && !array_erase_i && !array_allow_o
      |=> security_reg_o[obl_pkg::BIT_PROG_FAIL])
      else $error("program fail flag not set");
   erase_fail_set_a: assert property (ce_i && erase_fail_i
                                      |=> security_reg_o[obl_pkg::BIT_ERASE_FAIL])
      else $error("erase fail flag not set");
   so_release_a: assert property (ce_i && cs_n_s |=> so_oe_n_o)
      else $error("serial out driven while deselected");
   otp_refuse_a: assert property (opcode_valid_o && otp_mode_o && opcode_o == OP_WRITE_SEC
                                  |-> !opcode_allowed_o)
      else $error("register write allowed in secured mode");
   cp_mirror_a: assert property (security_reg_o[obl_pkg::BIT_CONT_PROG] == continuous_program_mode_i)
      else $error("continuous program bit wrong");

   enter_otp_c: cover property (!otp_mode_o ##1 otp_mode_o);
   read_reg_c: cover property (!so_oe_n_o ##1 so_oe_n_o);
   single_lock_c: cover property (s.lk_one && s.lk_val);
   whole_unlock_c: cover property (s.lk_all && !s.lk_val);
endmodule // obl_core
`default_nettype wire

// file: obl_pkg.sv
`default_nettype none
package obl_pkg;
   // fixed opcodes of the serial command set
   localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
   localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
   localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
   localparam logic [7:0] OP_HALF_BLOCK_ERASE = 8'h52;
   localparam logic [7:0] OP_BLOCK_ERASE = 8'hd8;
   localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
   localparam logic [7:0] OP_CHIP_ERASE_B = 8'hc7;
   localparam logic [7:0] OP_CLEAR_FAIL = 8'h30;
   localparam logic [7:0] OP_SINGLE_LOCK = 8'h36;
   localparam logic [7:0] OP_SINGLE_UNLOCK = 8'h39;
   localparam logic [7:0] OP_WHOLE_LOCK = 8'h7e;
   localparam logic [7:0] OP_WHOLE_UNLOCK = 8'h98;
   // default opcodes for the configurable commands (arbitrary values)
   localparam logic [7:0] OP_ENTER_SECURE_DEF = 8'hb1;
   localparam logic [7:0] OP_EXIT_SECURE_DEF = 8'hc1;
   localparam logic [7:0] OP_READ_SEC_DEF = 8'h2b;
   localparam logic [7:0] OP_WRITE_SEC_DEF = 8'h2f;
   localparam logic [7:0] OP_PROTECT_SEL_DEF = 8'h68;
   // security register bit positions
   localparam int BIT_FACTORY_LOCK = 0;
   localparam int BIT_LOCKDOWN = 1;
   localparam int BIT_CONT_PROG = 4;
   localparam int BIT_PROG_FAIL = 5;
   localparam int BIT_ERASE_FAIL = 6;
   localparam int BIT_PROTECT_SEL = 7;
   // frame layout: opcode byte plus three address bytes
   localparam logic [2:0] BYTES_OPCODE_ONLY = 3'h1;
   localparam logic [2:0] BYTES_WITH_ADDR = 3'h4;
   localparam logic [2:0] LAST_BIT = 3'h7;
   // lock store geometry: 64 KiB blocks, 4 KiB sectors in the end blocks
   localparam int NUM_BLOCKS_DEF = 256;
   localparam int SECT_PER_BLOCK = 16;
   // pin synchroniser reset levels: cs_n, sclk, si, wp_n
   localparam logic [3:0] PIN_RST_VAL = 4'h9;
endpackage
`default_nettype wire

// file: obl_sync.sv
`timescale 1ns/1ns
`default_nettype none
module obl_sync #(
   parameter int W = 4,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic clk_i,          // system clock
   input wire logic sys_rst_i,      // synchronous reset, high
   input wire logic ce_i,           // clock enable
   input wire logic [W-1:0] d_i,    // asynchronous pin levels
   output logic [W-1:0] q_o         // synchronised levels
);
   typedef struct packed {
      logic [W-1:0] ff1;
      logic [W-1:0] ff2;
   } obl_sync_state_type;
   obl_sync_state_type s;
   obl_sync_state_type next_s;

   if (W < 1) begin : g_chk
      $error("obl_sync: width must be at least one");
   end

   // first stage feeds only the second stage
   always_comb begin
      next_s = s;
      next_s.ff1 = d_i;
      next_s.ff2 = s.ff1;
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         s <= {RST_VAL, RST_VAL};
      end else if (ce_i) begin
         s <= next_s;
      end
   end

   assign q_o = s.ff2;
endmodule // obl_sync
`default_nettype wire

// file: obl_lock_mem.sv
`timescale 1ns/1ns
`default_nettype none
module obl_lock_mem #(
   parameter int NUM_BLOCKS = obl_pkg::NUM_BLOCKS_DEF
) (
   input wire logic clk_i,           // system clock
   input wire logic sys_rst_i,       // synchronous reset, high
   input wire logic ce_i,            // clock enable
   input wire logic wr_one_i,        // write one block or sector
   input wire logic wr_all_i,        // write every lock bit
   input wire logic wr_val_i,        // 1 locks, 0 unlocks
   input wire logic [23:0] wr_addr_i, // address chosen for wr_one_i
   input wire logic [23:0] rd_addr_i, // address being checked
   output logic locked_o             // lock state at rd_addr_i
);
   localparam int NSEC = 2 * obl_pkg::SECT_PER_BLOCK;
   typedef struct packed {
      logic [NUM_BLOCKS-1:0] blk;
      logic [NSEC-1:0] sec;
   } obl_lock_state_type;
   obl_lock_state_type s;
   obl_lock_state_type next_s;

   if (NUM_BLOCKS < 2 || NUM_BLOCKS > 256) begin : g_chk
      $error("obl_lock_mem: block count must be 2..256");
   end

   // first and last block are split into sectors, the rest lock whole
   function automatic logic in_sectors(input logic [23:0] a);
      return (a[23:16] == 8'h00) || (a[23:16] == 8'(NUM_BLOCKS - 1));
   endfunction

   function automatic logic [4:0] sec_index(input logic [23:0] a);
      return {(a[23:16] != 8'h00), a[15:12]};
   endfunction

   // writes; after reset every lock bit is set
   always_comb begin
      next_s = s;
      if (wr_all_i) begin
         next_s.blk = {NUM_BLOCKS{wr_val_i}};
         next_s.sec = {NSEC{wr_val_i}};
      end else if (wr_one_i) begin
         if (in_sectors(wr_addr_i)) begin
            next_s.sec[sec_index(wr_addr_i)] = wr_val_i;
         end else begin
            next_s.blk[wr_addr_i[23:16]] = wr_val_i;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         s <= '1;
      end else if (ce_i) begin
         s <= next_s;
      end
   end

   // addresses beyond the array count as locked
   assign locked_o = in_sectors(rd_addr_i) ? s.sec[sec_index(rd_addr_i)] :
                     (32'(rd_addr_i[23:16]) >= NUM_BLOCKS) ? 1'b1 : s.blk[rd_addr_i[23:16]];
endmodule // obl_lock_mem
`default_nettype wire

// file: obl_host.sv
`timescale 1ns/1ns
`default_nettype none
module obl_host (
   output var logic cs_n_o,   // chip select, low selects
   output var logic sclk_o,   // link clock, idle low
   output var logic si_o,     // serial data to device
   input wire logic so_i,     // serial data from device
   input wire logic so_oe_n_i // device drive enable, low drives
);
   // idle: deselected, clock parked low
   initial begin
      cs_n_o = 1'b1;
      sclk_o = 1'b0;
      si_o = 1'b0;
   end
   // one frame: nb bits of d sent msb first, then rb bits read back
   task automatic frame(input logic [31:0] d, input int nb, input int rb,
                        output logic [15:0] rd);
      int i;
      rd = 16'h0000;
      cs_n_o = 1'b0;
      #203;
      for (i = 0; i < nb + rb; i++) begin
         si_o = (i < nb) ? d[31 - i] : ~si_o;
         #62;
         sclk_o = 1'b1;
         // an undriven output reads unknown so it can never match
         if (i >= nb) begin
            rd = {rd[14:0], so_oe_n_i ? 1'bx : so_i};
         end
         #63;
         sclk_o = 1'b0;
      end
      #100;
      cs_n_o = 1'b1;
      si_o = ~si_o;  // released line must not keep the last bit
      #200;
   endtask
endmodule // obl_host
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic wp_n_i = 1'b1;
   logic nv_fact = 1'b1;
   logic nv_lkdn = 1'b0;
   logic nv_psel = 1'b0;
   logic continuous_program_mode_i = 1'b0;
   logic pfail = 1'b0;
   logic efail = 1'b0;
   logic array_req_i = 1'b0;
   logic array_erase_i = 1'b0;
   logic [23:0] array_addr_i = 24'h000000;
   logic range_hit = 1'b0;
   logic cs_n, sclk, si, so, so_oe_n, lk_set, ps_set, array_allow_o, otp_mode_o;
   logic opv, op_ok;
   logic [7:0] opcode_o, security_reg_o;
   logic [15:0] rd;
   int failures = 0;
   int checks_done = 0;
   int lk_pulses = 0;
   int ps_pulses = 0;
   int op_pulses = 0;
   obl_host i_obl_host (.cs_n_o(cs_n), .sclk_o(sclk), .si_o(si), .so_i(so),
      .so_oe_n_i(so_oe_n));
   obl_core i_obl_core (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(1'b1),
      .cs_n_i(cs_n), .sclk_i(sclk), .si_i(si), .wp_n_i(wp_n_i), .so_o(so),
      .so_oe_n_o(so_oe_n), .nv_factory_lock_i(nv_fact), .nv_lockdown_i(nv_lkdn),
      .nv_protect_sel_i(nv_psel), .nv_lockdown_set_o(lk_set),
      .nv_protect_sel_set_o(ps_set), .continuous_program_mode_i(continuous_program_mode_i), .program_fail_i(pfail),
      .erase_fail_i(efail), .array_req_i(array_req_i), .array_erase_i(array_erase_i),
      .array_addr_i(array_addr_i), .range_protect_hit_i(range_hit),
      .array_allow_o(array_allow_o), .otp_mode_o(otp_mode_o), .opcode_o(opcode_o),
      .opcode_valid_o(opv), .opcode_allowed_o(op_ok), .security_reg_o(security_reg_o));
   initial forever #5 clk_i = ~clk_i;
   // count store pulses so refused writes show up as missing pulses
   always @(posedge clk_i) begin
      if (lk_set === 1'b1) lk_pulses++;
      if (ps_set === 1'b1) ps_pulses++;
      if (opv === 1'b1) op_pulses++;
   end
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp, input string what);
      chk8({7'h00, got}, {7'h00, exp}, what);
   endtask
   task automatic cmd(input logic [7:0] op, input logic [23:0] a, input int nb);
      i_obl_host.frame({op, a}, nb, 0, rd);
   endtask
   // program or erase request; the answer is combinational, look mid-cycle
   task automatic areq(input logic er, input logic [23:0] a, input logic exp);
      @(posedge clk_i);
      array_req_i <= 1'b1;
      array_erase_i <= er;
      array_addr_i <= a;
      @(negedge clk_i);
      chk1(array_allow_o, exp, "array allow");
      @(posedge clk_i);
      array_req_i <= 1'b0;
      repeat (2) @(posedge clk_i);
   endtask
   task automatic do_reset();
      @(posedge clk_i);
      sys_rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      repeat (6) @(posedge clk_i);
   endtask
   task automatic t_status();
      chk8(security_reg_o, 8'h01, "reset value");
      i_obl_host.frame({obl_pkg::OP_READ_SEC_DEF, 24'h0}, 8, 16, rd);
      chk8(rd[15:8], 8'h01, "read first");
      chk8(rd[7:0], 8'h01, "read repeat");
      @(posedge clk_i) continuous_program_mode_i <= 1'b1;
      @(negedge clk_i) chk8(security_reg_o, 8'h11, "cp bit");
      @(posedge clk_i) continuous_program_mode_i <= 1'b0;
      @(posedge clk_i) pfail <= 1'b1;
      @(posedge clk_i) pfail <= 1'b0;
      @(negedge clk_i) chk8(security_reg_o, 8'h21, "prog fail");
      @(posedge clk_i) efail <= 1'b1;
      @(posedge clk_i) efail <= 1'b0;
      @(negedge clk_i) chk8(security_reg_o, 8'h61, "erase fail");
      cmd(obl_pkg::OP_CLEAR_FAIL, 24'h0, 8);
      chk8(security_reg_o, 8'h01, "flags cleared");
      $display("status test done");
   endtask
   task automatic t_otp();
      int n;
      n = op_pulses;
      cmd(obl_pkg::OP_ENTER_SECURE_DEF, 24'h0, 8);
      chk8(8'(op_pulses - n), 8'h01, "opcode pulse");
      chk1(otp_mode_o, 1'b1, "enter otp");
      cmd(obl_pkg::OP_STATUS_WRITE, 24'h0, 8);
      chk8(opcode_o, obl_pkg::OP_STATUS_WRITE, "opcode out");
      chk1(op_ok, 1'b0, "status write refused");
      cmd(obl_pkg::OP_WRITE_SEC_DEF, 24'h0, 8);
      chk8(8'(lk_pulses), 8'h00, "reg write refused");
      areq(1'b1, 24'h010000, 1'b0);
      chk8(security_reg_o, 8'h41, "erase refused flag");
      areq(1'b0, 24'h000010, 1'b1);
      cmd(obl_pkg::OP_EXIT_SECURE_DEF, 24'h0, 8);
      chk1(otp_mode_o, 1'b0, "exit otp");
      cmd(obl_pkg::OP_CLEAR_FAIL, 24'h0, 8);
      $display("otp test done");
   endtask
   task automatic t_lockdown();
      i_obl_host.frame({obl_pkg::OP_WRITE_SEC_DEF, 24'h0}, 9, 0, rd);
      chk8(8'(lk_pulses), 8'h00, "off boundary write");
      cmd(obl_pkg::OP_WRITE_SEC_DEF, 24'h0, 8);
      chk8(8'(lk_pulses), 8'h01, "lockdown pulse");
      chk8(security_reg_o, 8'h03, "lockdown bit");
      cmd(obl_pkg::OP_ENTER_SECURE_DEF, 24'h0, 8);
      areq(1'b0, 24'h000010, 1'b0);
      chk8(security_reg_o, 8'h23, "locked otp program");
      cmd(obl_pkg::OP_EXIT_SECURE_DEF, 24'h0, 8);
      cmd(obl_pkg::OP_WRITE_SEC_DEF, 24'h0, 8);
      chk8(8'(lk_pulses), 8'h01, "second lockdown");
      cmd(obl_pkg::OP_CLEAR_FAIL, 24'h0, 8);
      $display("lockdown test done");
   endtask
   task automatic t_protect();
      @(posedge clk_i) range_hit <= 1'b1;
      areq(1'b0, 24'h120000, 1'b0);
      cmd(obl_pkg::OP_PROTECT_SEL_DEF, 24'h0, 8);
      chk8(8'(ps_pulses), 8'h01, "select pulse");
      // the range-protected program just above left the program fail flag set
      chk8(security_reg_o, 8'ha3, "select bit");
      areq(1'b0, 24'h120000, 1'b0);
      cmd(obl_pkg::OP_WRITE_ENABLE, 24'h0, 8);
      cmd(obl_pkg::OP_SINGLE_UNLOCK, 24'h120000, 32);
      areq(1'b0, 24'h123400, 1'b1);
      cmd(obl_pkg::OP_WRITE_ENABLE, 24'h0, 8);
      cmd(obl_pkg::OP_SINGLE_UNLOCK, 24'h001000, 32);
      areq(1'b0, 24'h001000, 1'b1);
      areq(1'b0, 24'h002000, 1'b0);
      cmd(obl_pkg::OP_WRITE_ENABLE, 24'h0, 8);
      cmd(obl_pkg::OP_SINGLE_UNLOCK, 24'h130000, 31);
      areq(1'b0, 24'h130000, 1'b0);
      @(posedge clk_i) wp_n_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      areq(1'b0, 24'h120000, 1'b0);
      @(posedge clk_i) wp_n_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      // the cut unlock above left the write enable latch set, so this lock runs
      cmd(obl_pkg::OP_SINGLE_LOCK, 24'h120000, 32);
      areq(1'b0, 24'h120000, 1'b0);
      cmd(obl_pkg::OP_WHOLE_UNLOCK, 24'h0, 8);
      areq(1'b1, 24'h400000, 1'b0);
      cmd(obl_pkg::OP_WRITE_ENABLE, 24'h0, 8);
      cmd(obl_pkg::OP_WHOLE_UNLOCK, 24'h0, 8);
      areq(1'b1, 24'h400000, 1'b1);
      cmd(obl_pkg::OP_WRITE_ENABLE, 24'h0, 8);
      cmd(obl_pkg::OP_WHOLE_LOCK, 24'h0, 8);
      areq(1'b1, 24'h400000, 1'b0);
      $display("protect test done");
   endtask
   task automatic t_reset2();
      nv_lkdn <= 1'b1;
      nv_psel <= 1'b1;
      do_reset();
      chk8(security_reg_o, 8'h83, "after power on");
      areq(1'b0, 24'h123400, 1'b0);
      $display("second reset test done");
   endtask
   task automatic complete_run();
      $display("checks %0d, mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // watchdog: a hang counts as a mismatch
   initial begin
      #500000;
      failures++;
      $display("mismatch at %0t: run timed out", $time);
      complete_run();
   end
   initial begin
      repeat (2) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      repeat (6) @(posedge clk_i);
      t_status();
      t_otp();
      t_lockdown();
      t_protect();
      t_reset2();
      complete_run();
   end
endmodule // tb_top
`default_nettype wire
